// ===== verilog/oc_pwm_pkg.sv
package oc_pwm_pkg;
   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] CHAN_OFS = 8'h04;
   localparam logic [7:0] RELOAD_OFS = 8'h08;
   localparam logic [7:0] COMPARE_OFS = 8'h0C;
   localparam logic [7:0] COUNT_OFS = 8'h10;
   localparam logic [7:0] STATUS_OFS = 8'h14;
   localparam logic [7:0] EVENT_OFS = 8'h18;
   localparam logic [7:0] OUT_OFS = 8'h1C;
   // ----------------------------------------
   // CTRL fields
   // ----------------------------------------
   localparam int CTRL_CEN_BIT = 0;
   localparam int CTRL_DIR_BIT = 1;
   localparam int CTRL_CMS_LSB = 2;
   localparam int CTRL_RELOAD_PRELOAD_EN_BIT = 4;
   localparam int CTRL_MOE_BIT = 5;
   localparam int CTRL_DTG_LSB = 8;
   // ----------------------------------------
   // CHAN fields
   // ----------------------------------------
   localparam int CHAN_MODE_LSB = 0;
   localparam int CHAN_PE_BIT = 3;
   localparam int CHAN_SEL_LSB = 4;
   localparam int CHAN_MP_BIT = 6;
   localparam int CHAN_CP_BIT = 7;
   localparam int CHAN_ME_BIT = 8;
   localparam int CHAN_CE_BIT = 9;
   localparam int CHAN_IE_BIT = 10;
   localparam int CHAN_DE_BIT = 11;
   localparam int CHAN_DS_BIT = 12;
   localparam int CHAN_OISM_BIT = 13;
   localparam int CHAN_OISC_BIT = 14;
   localparam int EVENT_UG_BIT = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] CHAN_RESET = 32'h0000_0000;

   typedef enum logic [2:0] {
      MODE_FROZEN = 3'b000,
      MODE_SET_ACT = 3'b001,
      MODE_SET_INACT = 3'b010,
      MODE_TOGGLE = 3'b011,
      MODE_FORCE_LOW = 3'b100,
      MODE_FORCE_HIGH = 3'b101,
      MODE_PWM1 = 3'b110,
      MODE_PWM2 = 3'b111
   } compare_mode_type;

   localparam logic [1:0] ALIGN_EDGE = 2'b00;
   localparam logic [1:0] ALIGN_DOWN_FLAG = 2'b01;
   localparam logic [1:0] ALIGN_UP_FLAG = 2'b10;
   localparam logic [1:0] SEL_OUTPUT = 2'b00;
endpackage

// ===== verilog/deadtime_delay.sv
`timescale 1ns/1ps
// Rising-edge delay: output follows input low at once, rises only after
// the input has stayed high for dead_cycles clocks. Short pulses vanish.
module deadtime_delay #(
   parameter int DT_W = 8
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic level_in,
   input wire logic [DT_W-1:0] dead_cycles,
   output logic level_out
);
   logic [DT_W-1:0] cnt_r;
   wire done = (cnt_r >= dead_cycles);

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_r <= '0;
         level_out <= 1'b0;
      end else if (!level_in) begin
         cnt_r <= '0;
         level_out <= 1'b0;
      end else begin
         if (!done) begin
            cnt_r <= cnt_r + 1'b1;
         end
         level_out <= done;
      end
   end
endmodule

// ===== verilog/oc_pwm_channel.sv
`timescale 1ns/1ps
module oc_pwm_channel #(
   parameter int CNT_W = 16,
   parameter int DT_W = 8
) (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic main_output,
   output logic complementary_output,
   output logic main_oe,
   output logic comp_oe,
   output logic match_irq,
   output logic match_dma_req
);
   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [31:0] ctrl_r;
   logic [31:0] chan_r;
   logic [CNT_W-1:0] reload_pre_r, reload_sh_r;
   logic [CNT_W-1:0] compare_pre_r, compare_sh_r;
   logic [CNT_W-1:0] counter_value_r, counter_value_nxt;
   logic compare_match_flag_r, upd_flag_r;
   logic ref_waveform_r, ref_waveform_nxt;
   logic dir_nxt;

   wire acc = psel && penable;
   wire wr = acc && pwrite;
   wire rd = acc && !pwrite;
   wire hit_ctrl = (paddr == oc_pwm_pkg::CTRL_OFS);
   wire hit_chan = (paddr == oc_pwm_pkg::CHAN_OFS);
   wire hit_rel = (paddr == oc_pwm_pkg::RELOAD_OFS);
   wire hit_cmp = (paddr == oc_pwm_pkg::COMPARE_OFS);
   wire hit_cnt = (paddr == oc_pwm_pkg::COUNT_OFS);
   wire hit_sts = (paddr == oc_pwm_pkg::STATUS_OFS);
   wire hit_evt = (paddr == oc_pwm_pkg::EVENT_OFS);
   wire hit_out = (paddr == oc_pwm_pkg::OUT_OFS);
   wire mapped = hit_ctrl | hit_chan | hit_rel | hit_cmp | hit_cnt | hit_sts | hit_evt | hit_out;

   // ----------------------------------------
   // Field decode
   // ----------------------------------------
   wire counter_enable = ctrl_r[oc_pwm_pkg::CTRL_CEN_BIT];
   wire dir_down = ctrl_r[oc_pwm_pkg::CTRL_DIR_BIT];
   wire [1:0] alignment_select = ctrl_r[oc_pwm_pkg::CTRL_CMS_LSB +: 2];
   wire reload_preload_en = ctrl_r[oc_pwm_pkg::CTRL_RELOAD_PRELOAD_EN_BIT];
   wire master_out_en = ctrl_r[oc_pwm_pkg::CTRL_MOE_BIT];
   wire [DT_W-1:0] deadtime_setting = ctrl_r[oc_pwm_pkg::CTRL_DTG_LSB +: DT_W];
   wire [2:0] compare_mode_field = chan_r[oc_pwm_pkg::CHAN_MODE_LSB +: 3];
   wire compare_preload_en = chan_r[oc_pwm_pkg::CHAN_PE_BIT];
   wire [1:0] channel_direction_select = chan_r[oc_pwm_pkg::CHAN_SEL_LSB +: 2];
   wire main_polarity = chan_r[oc_pwm_pkg::CHAN_MP_BIT];
   wire comp_polarity = chan_r[oc_pwm_pkg::CHAN_CP_BIT];
   wire main_out_en = chan_r[oc_pwm_pkg::CHAN_ME_BIT];
   wire comp_out_en = chan_r[oc_pwm_pkg::CHAN_CE_BIT];
   wire match_irq_en = chan_r[oc_pwm_pkg::CHAN_IE_BIT];
   wire match_dma_en = chan_r[oc_pwm_pkg::CHAN_DE_BIT];
   wire dma_request_select = chan_r[oc_pwm_pkg::CHAN_DS_BIT];
   wire idle_level_main = chan_r[oc_pwm_pkg::CHAN_OISM_BIT];
   wire idle_level_comp = chan_r[oc_pwm_pkg::CHAN_OISC_BIT];
   wire out_mode = (channel_direction_select == oc_pwm_pkg::SEL_OUTPUT);
   wire center = (alignment_select != oc_pwm_pkg::ALIGN_EDGE);

   // ----------------------------------------
   // Time base
   // ----------------------------------------
   wire update_generate = wr && hit_evt && pwdata[oc_pwm_pkg::EVENT_UG_BIT];
   wire cnt_wr = wr && hit_cnt;
   wire [CNT_W-1:0] cnt_wdata = pwdata[CNT_W-1:0];
   wire at_top = (counter_value_r >= reload_sh_r);
   wire at_zero = (counter_value_r == '0);
   // Hardware wrap or reversal; software counter writes never make one
   wire wrap_evt = counter_enable && !cnt_wr &&
                   (center ? ((!dir_down && at_top) || (dir_down && at_zero))
                           : (dir_down ? at_zero : at_top));
   wire update_event = update_generate || wrap_evt;

   always_comb begin
      counter_value_nxt = counter_value_r;
      dir_nxt = dir_down;
      if (cnt_wr) begin
         counter_value_nxt = cnt_wdata;
         if (center && cnt_wdata == '0) begin
            dir_nxt = 1'b0;
         end else if (center && cnt_wdata == reload_sh_r) begin
            dir_nxt = 1'b1;
         end // else above-reload or mid values keep direction
      end else if (update_generate) begin
         counter_value_nxt = dir_down && !center ? reload_sh_r : '0;
      end else if (counter_enable) begin
         // Starting direction is whatever the direction bit holds
         if (center) begin
            if (!dir_down && at_top) begin
               dir_nxt = 1'b1;
               counter_value_nxt = counter_value_r - 1'b1;
            end else if (dir_down && at_zero) begin
               dir_nxt = 1'b0;
               counter_value_nxt = counter_value_r + 1'b1;
            end else begin
               counter_value_nxt = dir_down ? counter_value_r - 1'b1 : counter_value_r + 1'b1;
            end
         end else if (dir_down) begin
            counter_value_nxt = at_zero ? reload_sh_r : counter_value_r - 1'b1;
         end else begin
            counter_value_nxt = at_top ? '0 : counter_value_r + 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Compare and reference
   // ----------------------------------------
   wire match = counter_enable && (counter_value_r == compare_sh_r);
   wire flag_dir_ok = !center || (alignment_select == oc_pwm_pkg::ALIGN_DOWN_FLAG ? dir_down :
                      alignment_select == oc_pwm_pkg::ALIGN_UP_FLAG ? !dir_down : 1'b1);
   wire match_evt = match && flag_dir_ok;
   wire over_top = (compare_sh_r > reload_sh_r);
   wire pwm1_ref = over_top ? 1'b1 :
                   dir_down ? !(counter_value_r > compare_sh_r) :
                   (counter_value_r < compare_sh_r);

   always_comb begin
      ref_waveform_nxt = ref_waveform_r; // update event is ignored here
      case (compare_mode_field)
         oc_pwm_pkg::MODE_FROZEN: ref_waveform_nxt = ref_waveform_r;
         oc_pwm_pkg::MODE_SET_ACT: if (match) ref_waveform_nxt = 1'b1;
         oc_pwm_pkg::MODE_SET_INACT: if (match) ref_waveform_nxt = 1'b0;
         oc_pwm_pkg::MODE_TOGGLE: if (match) ref_waveform_nxt = !ref_waveform_r;
         oc_pwm_pkg::MODE_FORCE_LOW: ref_waveform_nxt = 1'b0;
         oc_pwm_pkg::MODE_FORCE_HIGH: ref_waveform_nxt = 1'b1;
         oc_pwm_pkg::MODE_PWM1: ref_waveform_nxt = pwm1_ref;
         default: ref_waveform_nxt = !pwm1_ref;
      endcase
      if (!out_mode) begin
         ref_waveform_nxt = 1'b0;
      end
   end

   // ----------------------------------------
   // Output stage with dead time
   // ----------------------------------------
   wire both_en = main_out_en && comp_out_en;
   // Master disable steers both legs to idle levels, through the delay modules with dt_eff forced to zero
   wire main_raw = master_out_en ? ref_waveform_r : idle_level_main ^ main_polarity;
   wire comp_raw = master_out_en ? (both_en ? !ref_waveform_r : ref_waveform_r)
                                 : idle_level_comp ^ comp_polarity;
   wire [DT_W-1:0] dt_eff = (both_en && master_out_en) ? deadtime_setting : '0;
   wire main_dly, comp_dly;

   deadtime_delay #(.DT_W(DT_W)) u_main_dly (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .level_in(main_raw),
      .dead_cycles(dt_eff),
      .level_out(main_dly)
   );

   deadtime_delay #(.DT_W(DT_W)) u_comp_dly (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .level_in(comp_raw),
      .dead_cycles(dt_eff),
      .level_out(comp_dly)
   );

   // Both legs active at once is blocked outright when both are enabled
   wire clash = both_en && main_dly && comp_dly;
   wire main_act = main_out_en && main_dly && !clash;
   wire comp_act = comp_out_en && comp_dly && !clash;
   wire main_lvl = main_act ^ main_polarity;
   wire comp_lvl = comp_act ^ comp_polarity;

   // ----------------------------------------
   // Register file and state
   // ----------------------------------------
   wire flag_clr = wr && hit_sts && !pwdata[0];
   wire [31:0] ctrl_wdata = {pwdata[31:2], dir_nxt, pwdata[0]};
   wire [31:0] rd_mux = hit_ctrl ? ctrl_r : hit_chan ? chan_r :
                        hit_rel ? 32'(reload_pre_r) : hit_cmp ? 32'(compare_pre_r) :
                        hit_cnt ? 32'(counter_value_r) :
                        hit_sts ? {30'h0, upd_flag_r, compare_match_flag_r} :
                        hit_out ? {29'h0, ref_waveform_r, complementary_output, main_output} :
                        32'h0000_0000;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_r <= oc_pwm_pkg::CTRL_RESET;
         chan_r <= oc_pwm_pkg::CHAN_RESET;
         reload_pre_r <= '0;
         reload_sh_r <= '0;
         compare_pre_r <= '0;
         compare_sh_r <= '0;
         counter_value_r <= '0;
         compare_match_flag_r <= 1'b0;
         upd_flag_r <= 1'b0;
         ref_waveform_r <= 1'b0;
      end else begin
         // Direction bit is ignored on writes in center mode
         ctrl_r <= (wr && hit_ctrl) ? (center ? ctrl_wdata : pwdata)
                                    : {ctrl_r[31:2], dir_nxt, ctrl_r[0]};
         if (wr && hit_chan) chan_r <= pwdata;
         if (wr && hit_rel) reload_pre_r <= pwdata[CNT_W-1:0];
         if (wr && hit_cmp) compare_pre_r <= pwdata[CNT_W-1:0];
         if (!reload_preload_en && wr && hit_rel) begin
            reload_sh_r <= pwdata[CNT_W-1:0];
         end else if (update_event) begin
            reload_sh_r <= reload_pre_r;
         end
         if (!compare_preload_en && wr && hit_cmp) begin
            compare_sh_r <= pwdata[CNT_W-1:0];
         end else if (update_event && compare_preload_en) begin
            compare_sh_r <= compare_pre_r;
         end
         counter_value_r <= counter_value_nxt;
         // Set wins over a clear in the same cycle
         compare_match_flag_r <= match_evt || (compare_match_flag_r && !flag_clr);
         upd_flag_r <= update_event || (upd_flag_r && !(wr && hit_sts && !pwdata[1]));
         ref_waveform_r <= ref_waveform_nxt;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
         main_output <= 1'b0;
         complementary_output <= 1'b0;
         main_oe <= 1'b0;
         comp_oe <= 1'b0;
         match_irq <= 1'b0;
         match_dma_req <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
         prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0000_0000;
         main_output <= main_lvl;
         complementary_output <= comp_lvl;
         main_oe <= main_out_en;
         comp_oe <= comp_out_en;
         match_irq <= match_evt && match_irq_en;
         match_dma_req <= match_dma_en &&
                          (dma_request_select ? update_event : match_evt);
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_FORCE_HIGH: assert property (@(posedge core_clk) disable iff (!rst_b)
      out_mode && compare_mode_field == oc_pwm_pkg::MODE_FORCE_HIGH |=> ref_waveform_r)
      else $error("forced high not applied");
   AST_FORCE_LOW: assert property (@(posedge core_clk) disable iff (!rst_b)
      compare_mode_field == oc_pwm_pkg::MODE_FORCE_LOW |=> !ref_waveform_r)
      else $error("forced low not applied");
   AST_FLAG_SET: assert property (@(posedge core_clk) disable iff (!rst_b)
      match_evt |=> compare_match_flag_r)
      else $error("match flag not set");
   AST_TOGGLE: assert property (@(posedge core_clk) disable iff (!rst_b)
      out_mode && compare_mode_field == oc_pwm_pkg::MODE_TOGGLE && match
      |=> ref_waveform_r != $past(ref_waveform_r))
      else $error("toggle missed");
   AST_IRQ: assert property (@(posedge core_clk) disable iff (!rst_b)
      match_irq |-> $past(match_evt) && $past(match_irq_en))
      else $error("spurious match interrupt");
   AST_IMMEDIATE: assert property (@(posedge core_clk) disable iff (!rst_b)
      wr && hit_cmp && !compare_preload_en |=> compare_sh_r == $past(pwdata[CNT_W-1:0]))
      else $error("compare write not immediate");
   AST_PWM1_UP: assert property (@(posedge core_clk) disable iff (!rst_b)
      out_mode && compare_mode_field == oc_pwm_pkg::MODE_PWM1 && !dir_down && !over_top
      |=> ref_waveform_r == ($past(counter_value_r) < $past(compare_sh_r)))
      else $error("pwm1 up level wrong");
   AST_NO_OVERLAP: assert property (@(posedge core_clk) disable iff (!rst_b)
      both_en ##1 both_en |-> !((main_output ^ main_polarity) && (complementary_output ^ comp_polarity)))
      else $error("both outputs active");
   AST_DEADTIME: assert property (@(posedge core_clk) disable iff (!rst_b)
      $rose(main_dly) && dt_eff != '0 |-> $past(main_raw, 2))
      else $error("main rose without dead time");
endmodule

// ===== dv/switch_load_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Load on the two switch pins
// ----------------------------------------
// Counts clocks each leg is driven on, and clocks with both on (shoot-through)
module switch_load_model (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic main_output,
   input wire logic complementary_output,
   input wire logic clear,
   output logic [15:0] main_hi,
   output logic [15:0] comp_hi,
   output logic [15:0] both_hi
);
   // Clear is synchronous so the reset branch stays constant-only
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         main_hi <= 16'h0000;
         comp_hi <= 16'h0000;
         both_hi <= 16'h0000;
      end else if (clear) begin
         main_hi <= 16'h0000;
         comp_hi <= 16'h0000;
         both_hi <= 16'h0000;
      end else begin
         main_hi <= main_hi + {15'h0000, main_output};
         comp_hi <= comp_hi + {15'h0000, complementary_output};
         both_hi <= both_hi + {15'h0000, main_output & complementary_output};
      end
   end
endmodule

// ===== dv/timer_output_compare_pwm_deadtime_tb.sv
`timescale 1ns/1ps
module timer_output_compare_pwm_deadtime_tb;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic clr = 1'b0, irq_seen = 1'b0, dma_seen = 1'b0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
   logic pready, pslverr, main_output, complementary_output, main_oe, comp_oe;
   logic match_irq, match_dma_req;
   logic [15:0] main_hi, comp_hi, both_hi;
   int fails = 0, compares = 0;
   localparam logic [31:0] ME = 32'h1 << oc_pwm_pkg::CHAN_ME_BIT;
   localparam logic [31:0] CE = 32'h1 << oc_pwm_pkg::CHAN_CE_BIT;
   localparam logic [31:0] MP = 32'h1 << oc_pwm_pkg::CHAN_MP_BIT;
   localparam logic [31:0] CP = 32'h1 << oc_pwm_pkg::CHAN_CP_BIT;
   localparam logic [31:0] PE = 32'h1 << oc_pwm_pkg::CHAN_PE_BIT;
   localparam logic [31:0] IRQ_DMA = 32'h0000_0C00;
   localparam logic [15:0] SKIP = 16'hFFFF;

   oc_pwm_channel dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .main_output(main_output), .complementary_output(complementary_output),
      .main_oe(main_oe), .comp_oe(comp_oe), .match_irq(match_irq), .match_dma_req(match_dma_req));
   switch_load_model load (.core_clk(core_clk), .rst_b(rst_b), .main_output(main_output),
      .complementary_output(complementary_output), .clear(clr), .main_hi(main_hi),
      .comp_hi(comp_hi), .both_hi(both_hi));

   always #2 core_clk = ~core_clk;
   // Pulses last one clock, so they are caught here rather than polled over APB
   always @(posedge core_clk) begin
      if (clr) begin
         irq_seen <= 1'b0;
         dma_seen <= 1'b0;
      end else begin
         if (match_irq === 1'b1) irq_seen <= 1'b1;
         if (match_dma_req === 1'b1) dma_seen <= 1'b1;
      end
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic test_done;
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge core_clk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      for (i = 0; i < 20; i++) begin
         @(posedge core_clk);
         if (pready === 1'b1) break;
      end
      if (i == 20) begin fails++; test_done(); end
      rd = prdata; err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic rd_ref;
      repeat (4) @(posedge core_clk);
      apb(1'b0, oc_pwm_pkg::OUT_OFS, 32'h0);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic regs;
      apb(1'b0, oc_pwm_pkg::CTRL_OFS, 32'h0); check("ctrl reset", rd, oc_pwm_pkg::CTRL_RESET);
      apb(1'b0, oc_pwm_pkg::CHAN_OFS, 32'h0); check("chan reset", rd, oc_pwm_pkg::CHAN_RESET);
      apb(1'b1, oc_pwm_pkg::RELOAD_OFS, 32'h13);
      apb(1'b0, oc_pwm_pkg::RELOAD_OFS, 32'h0); check("reload", rd, 32'h13);
      apb(1'b1, 8'h40, 32'h5); check("unmapped wr err", {31'h0, err}, 32'h1);
      apb(1'b0, 8'h40, 32'h0); check("unmapped rd", rd, 32'h0);
      check("unmapped rd err", {31'h0, err}, 32'h1);
   endtask
   task automatic forced_pins;
      apb(1'b1, oc_pwm_pkg::CTRL_OFS, 32'h20);
      apb(1'b1, oc_pwm_pkg::CHAN_OFS, ME | 32'h5); rd_ref();
      check("forced high pin", {31'h0, main_output}, 32'h1);
      check("main oe", {31'h0, main_oe}, 32'h1);
      check("comp oe", {31'h0, comp_oe}, 32'h0);
      apb(1'b1, oc_pwm_pkg::CHAN_OFS, ME | MP | 32'h5); rd_ref();
      check("forced high inverted pin", {31'h0, main_output}, 32'h0);
      apb(1'b1, oc_pwm_pkg::CHAN_OFS, ME | 32'h4); rd_ref();
      check("forced low pin", {31'h0, main_output}, 32'h0);
   endtask
   // Each row: start level forced, then match mode, then level after the first match
   task automatic oc_modes;
      logic [2:0] m [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h4};
      logic [2:0] s [6] = '{3'h4, 3'h4, 3'h5, 3'h4, 3'h4, 3'h5};
      logic e [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
      for (int k = 0; k < 6; k++) begin
         apb(1'b1, oc_pwm_pkg::CTRL_OFS, 32'h20);
         apb(1'b1, oc_pwm_pkg::COUNT_OFS, 32'h0);
         apb(1'b1, oc_pwm_pkg::RELOAD_OFS, 32'h13);
         apb(1'b1, oc_pwm_pkg::COMPARE_OFS, 32'h5);
         apb(1'b1, oc_pwm_pkg::CHAN_OFS, ME | s[k]);
         apb(1'b1, oc_pwm_pkg::CHAN_OFS, ME | IRQ_DMA | m[k]);
         apb(1'b1, oc_pwm_pkg::STATUS_OFS, 32'h0);
         clr <= 1'b1;
         @(posedge core_clk);
         clr <= 1'b0;
         apb(1'b1, oc_pwm_pkg::CTRL_OFS, 32'h21);
         for (int j = 0; j < 20; j++) begin
            apb(1'b0, oc_pwm_pkg::STATUS_OFS, 32'h0);
            if (rd[0] === 1'b1) break;
         end
         check("match flag", {31'h0, rd[0]}, 32'h1);
         apb(1'b1, oc_pwm_pkg::CTRL_OFS, 32'h20); rd_ref();
         check("ref after match", {31'h0, rd[2]}, {31'h0, e[k]});
         check("irq", {31'h0, irq_seen}, 32'h1);
         check("dma", {31'h0, dma_seen}, 32'h1);
         apb(1'b1, oc_pwm_pkg::EVENT_OFS, 32'h1); rd_ref();
         check("ref after update", {31'h0, rd[2]}, {31'h0, e[k]});
      end
   endtask
   task automatic preload;
      apb(1'b1, oc_pwm_pkg::CTRL_OFS, 32'h20);
      apb(1'b1, oc_pwm_pkg::CHAN_OFS, PE | ME | 32'h6);
      apb(1'b1, oc_pwm_pkg::COMPARE_OFS, 32'h0);
      apb(1'b1, oc_pwm_pkg::EVENT_OFS, 32'h1);
      apb(1'b1, oc_pwm_pkg::COUNT_OFS, 32'h0); rd_ref();
      check("ref zero compare", {31'h0, rd[2]}, 32'h0);
      apb(1'b1, oc_pwm_pkg::COMPARE_OFS, 32'h5); rd_ref();
      check("ref preload held", {31'h0, rd[2]}, 32'h0);
      apb(1'b1, oc_pwm_pkg::EVENT_OFS, 32'h1); rd_ref();
      check("ref preload moved", {31'h0, rd[2]}, 32'h1);
      apb(1'b1, oc_pwm_pkg::CHAN_OFS, ME | 32'h6);
      apb(1'b1, oc_pwm_pkg::COMPARE_OFS, 32'h0); rd_ref();
      check("ref direct write", {31'h0, rd[2]}, 32'h0);
   endtask
   // Period 20 clocks; three periods are measured once the waveform has settled
   task automatic run_pwm(input logic [31:0] ctl, input logic [31:0] chan,
                          input logic [31:0] cmp, input logic [15:0] em, input logic [15:0] ec);
      apb(1'b1, oc_pwm_pkg::CTRL_OFS, 32'h0);
      apb(1'b1, oc_pwm_pkg::RELOAD_OFS, 32'h13);
      apb(1'b1, oc_pwm_pkg::CHAN_OFS, chan);
      apb(1'b1, oc_pwm_pkg::COMPARE_OFS, cmp);
      apb(1'b1, oc_pwm_pkg::EVENT_OFS, 32'h1);
      apb(1'b1, oc_pwm_pkg::CTRL_OFS, ctl | 32'h31);
      repeat (40) @(posedge core_clk);
      clr <= 1'b1;
      @(posedge core_clk);
      clr <= 1'b0;
      repeat (60) @(posedge core_clk);
      #1;
      if (em != SKIP) check("main high clocks", {16'h0, main_hi}, {16'h0, em} * 3);
      if (ec != SKIP) check("comp high clocks", {16'h0, comp_hi}, {16'h0, ec} * 3);
      if (em != SKIP && ec != SKIP) check("overlap", {16'h0, both_hi}, 32'h0);
   endtask
   task automatic pwm_edge;
      run_pwm(32'h0, PE | ME | 32'h6, 32'h6, 16'h6, SKIP);
      run_pwm(32'h0, PE | ME | 32'h7, 32'h6, 16'hE, SKIP);
      run_pwm(32'h0, PE | ME | 32'h6, 32'h0, 16'h0, SKIP);
      run_pwm(32'h0, PE | ME | 32'h6, 32'h19, 16'h14, SKIP);
      run_pwm(32'h2, PE | ME | 32'h6, 32'h6, 16'h7, SKIP);
      run_pwm(32'h2, PE | ME | 32'h6, 32'h19, 16'h14, SKIP);
      run_pwm(32'h0, PE | ME | MP | 32'h6, 32'h6, 16'hE, SKIP);
   endtask
   // Direction bit ownership and down-only match flag in center mode
   task automatic center;
      apb(1'b1, oc_pwm_pkg::CTRL_OFS, 32'h24);
      apb(1'b1, oc_pwm_pkg::RELOAD_OFS, 32'h13);
      apb(1'b1, oc_pwm_pkg::CHAN_OFS, ME);
      apb(1'b1, oc_pwm_pkg::COMPARE_OFS, 32'h5);
      apb(1'b1, oc_pwm_pkg::COUNT_OFS, 32'h13);
      apb(1'b0, oc_pwm_pkg::CTRL_OFS, 32'h0);
      check("dir at reload", {31'h0, rd[oc_pwm_pkg::CTRL_DIR_BIT]}, 32'h1);
      apb(1'b1, oc_pwm_pkg::COUNT_OFS, 32'h0);
      apb(1'b0, oc_pwm_pkg::CTRL_OFS, 32'h0);
      check("dir at zero", {31'h0, rd[oc_pwm_pkg::CTRL_DIR_BIT]}, 32'h0);
      apb(1'b1, oc_pwm_pkg::COUNT_OFS, 32'h30);
      apb(1'b1, oc_pwm_pkg::CTRL_OFS, 32'h26);
      apb(1'b0, oc_pwm_pkg::CTRL_OFS, 32'h0);
      check("dir kept", {31'h0, rd[oc_pwm_pkg::CTRL_DIR_BIT]}, 32'h0);
      apb(1'b1, oc_pwm_pkg::COUNT_OFS, 32'h0);
      apb(1'b1, oc_pwm_pkg::STATUS_OFS, 32'h0);
      apb(1'b1, oc_pwm_pkg::CTRL_OFS, 32'h25);
      repeat (8) @(posedge core_clk);
      apb(1'b0, oc_pwm_pkg::STATUS_OFS, 32'h0);
      check("no flag counting up", {31'h0, rd[0]}, 32'h0);
      for (int j = 0; j < 20; j++) begin
         apb(1'b0, oc_pwm_pkg::STATUS_OFS, 32'h0);
         if (rd[0] === 1'b1) break;
      end
      check("flag counting down", {31'h0, rd[0]}, 32'h1);
      apb(1'b1, oc_pwm_pkg::CTRL_OFS, 32'h24);
   endtask
   task automatic dead_time;
      run_pwm(32'h0300, PE | ME | CE | 32'h6, 32'h6, 16'h3, 16'hB);
      run_pwm(32'h0800, PE | ME | CE | 32'h6, 32'h6, 16'h0, 16'h6);
      run_pwm(32'h0300, PE | CE | 32'h6, 32'h6, SKIP, 16'h6);
      run_pwm(32'h0300, PE | CE | CP | 32'h6, 32'h6, SKIP, 16'hE);
   endtask

   initial begin
      repeat (20) @(posedge core_clk);
      rst_b <= 1'b1;
      regs();
      forced_pins();
      oc_modes();
      preload();
      pwm_edge();
      dead_time();
      center();
      test_done();
   end
endmodule
